// [hdl/csr_pkg.sv]
// Purpose: Shared constants for the charge setpoint register bank
// Assumes: Registers are reached through a byte-wide register port from the serial engine
// Notes: Currents are in mA, voltages in mV
package csr_pkg;
  // -------------------------------------------------------------------
  // Serial bus and register map
  // -------------------------------------------------------------------
  localparam logic [6:0] CSR_DEV_ADDR = 7'h6B;
  localparam logic [7:0] CSR_OFS_CHG_CUR = 8'h02;
  localparam logic [7:0] CSR_OFS_PRE_TERM = 8'h03;
  localparam logic [7:0] CSR_OFS_CHG_VOLT = 8'h04;
  localparam logic [7:0] CSR_RST_CHG_CUR = 8'h60;
  localparam logic [7:0] CSR_RST_PRE_TERM = 8'h11;
  localparam logic [7:0] CSR_RST_CHG_VOLT = 8'hB2;
  localparam logic [7:0] CSR_UNMAPPED_RD = 8'h00;
  // -------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------
  localparam int CSR_FAST_MSB = 7;
  localparam int CSR_FAST_LSB = 2;
  localparam int CSR_RSVD_BIT = 1;
  localparam int CSR_OVRD_BIT = 0;
  localparam int CSR_PRE_MSB = 7;
  localparam int CSR_PRE_LSB = 4;
  localparam int CSR_TERM_MSB = 3;
  localparam int CSR_TERM_LSB = 0;
  localparam int CSR_VOLT_MSB = 7;
  localparam int CSR_VOLT_LSB = 2;
  localparam int CSR_LOWV_BIT = 1;
  localparam int CSR_RECH_BIT = 0;
  // -------------------------------------------------------------------
  // Decode scaling
  // -------------------------------------------------------------------
  localparam logic [12:0] CSR_FAST_OFS_MA = 13'h0200;
  localparam logic [12:0] CSR_FAST_LSB_MA = 13'h0040;
  localparam logic [12:0] CSR_FAST_LOW_MAX_MA = 13'h09C0;
  localparam logic [12:0] CSR_FAST_REDUCE_DIV = 13'h0005;
  localparam logic [11:0] CSR_PT_OFS_MA = 12'h080;
  localparam logic [11:0] CSR_PT_LSB_MA = 12'h080;
  localparam logic [12:0] CSR_VOLT_OFS_MV = 13'h0DB0;
  localparam logic [12:0] CSR_VOLT_LSB_MV = 13'h0010;
  localparam logic [12:0] CSR_VOLT_MAX_MV = 13'h1130;
  localparam logic [11:0] CSR_LOWV_0_MV = 12'hAF0;
  localparam logic [11:0] CSR_LOWV_1_MV = 12'hBB8;
  localparam logic [8:0] CSR_RECH_0_MV = 9'h064;
  localparam logic [8:0] CSR_RECH_1_MV = 9'h12C;
endpackage : csr_pkg

// [hdl/csr_setpoint_bank.sv]
// Purpose: Three read/write charge setpoint registers and their decoded setpoints
// Assumes: Serial engine presents one-cycle read/write strobes with device address and offset
// Notes: Write data lands on the clock edge of the strobe; setpoints follow combinationally on that same edge
// Functional notes
// (RQ1) Fast current = 512 mA plus 64 mA per code step of bits 7:2.
// (RQ2) Lower-current variant clamps the fast current setpoint at 2496 mA.
// (RQ3) Fast current code resets to 011000, meaning 2048 mA.
// (RQ4) Host writes zero to bit 1 of the charge current register.
// (RQ5) Override bit gives 20% fast and 50% precharge current, else unchanged.
// (RQ6) Precharge and termination codes = 128 mA plus 128 mA per step.
// (RQ7) Precharge and termination codes both reset to 0001, meaning 256 mA.
// (RQ8) Voltage = 3.504 V plus 16 mV per step, top of range 4.400 V.
// (RQ9) Voltage code resets to 101100, meaning 4.208 V.
// (RQ10) Bit 1 of voltage register picks 2.8 V or 3.0 V, resets to 1.
// (RQ11) Bit 0 of voltage register picks 100 or 300 mV recharge, resets 0.
// (RQ12) Registers answer at serial address 6BH with reads and writes.
// (RQ13) Stored fields drive setpoints continuously, updated once a write completes.
`timescale 1ns/100ps
`default_nettype none
module csr_setpoint_bank
  import csr_pkg::*;
#(
  parameter bit LOW_CURRENT_VARIANT = 1'b0
) (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Register port from serial engine
  input wire logic [6:0] dev_addr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // Raw fields
  output logic [5:0] fast_current_code_o,
  output logic reduced_current_override_o,
  output logic [3:0] precondition_current_code_o,
  output logic [3:0] end_of_charge_current_code_o,
  output logic [5:0] target_voltage_code_o,
  output logic precondition_exit_threshold_o,
  output logic restart_threshold_select_o,
  // Decoded setpoints
  output logic [12:0] fast_current_ma_o,
  output logic [11:0] precharge_current_ma_o,
  output logic [11:0] term_current_ma_o,
  output logic [12:0] charge_voltage_mv_o,
  output logic [11:0] precharge_exit_mv_o,
  output logic [8:0] recharge_drop_mv_o
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] pt_decode(input logic [3:0] code);
    pt_decode = 12'(CSR_PT_OFS_MA + 12'(code) * CSR_PT_LSB_MA); // [RQ6]
  endfunction : pt_decode

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [7:0] chg_cur;
  logic [7:0] pre_term;
  logic [7:0] chg_volt;
  wire dev_sel = (dev_addr_i == CSR_DEV_ADDR); // [RQ12]
  wire sel_cur = dev_sel && (reg_addr_i == CSR_OFS_CHG_CUR);
  wire sel_pt = dev_sel && (reg_addr_i == CSR_OFS_PRE_TERM);
  wire sel_volt = dev_sel && (reg_addr_i == CSR_OFS_CHG_VOLT);
  wire wr_en = ce_i && reg_wr_i;
  // Bit 1 is held at zero so a careless host cannot leave junk there
  wire [7:0] cur_wdata = reg_wdata_i & ~(8'h01 << CSR_RSVD_BIT); // [RQ4]
  wire [7:0] next_rdata = sel_cur ? chg_cur :
                          sel_pt ? pre_term :
                          sel_volt ? chg_volt : CSR_UNMAPPED_RD;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chg_cur <= CSR_RST_CHG_CUR; // [RQ3]
      pre_term <= CSR_RST_PRE_TERM; // [RQ7]
      chg_volt <= CSR_RST_CHG_VOLT; // [RQ9] [RQ10] [RQ11]
    end else if (wr_en) begin
      if (sel_cur) chg_cur <= cur_wdata; // [RQ12]
      if (sel_pt) pre_term <= reg_wdata_i;
      if (sel_volt) chg_volt <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= CSR_UNMAPPED_RD;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= next_rdata; // [RQ12]
    end
  end

  assign reg_hit_o = sel_cur || sel_pt || sel_volt;

  // ---------------------------------------------------------------
  // Setpoint decode
  // ---------------------------------------------------------------
  wire [5:0] fast_code = chg_cur[CSR_FAST_MSB:CSR_FAST_LSB];
  wire ovrd = chg_cur[CSR_OVRD_BIT];
  wire [3:0] pre_code = pre_term[CSR_PRE_MSB:CSR_PRE_LSB];
  wire [3:0] term_code = pre_term[CSR_TERM_MSB:CSR_TERM_LSB];
  wire [5:0] volt_code = chg_volt[CSR_VOLT_MSB:CSR_VOLT_LSB];
  wire [12:0] fast_raw = 13'(CSR_FAST_OFS_MA + 13'(fast_code) * CSR_FAST_LSB_MA); // [RQ1]
  wire [12:0] fast_lim = (LOW_CURRENT_VARIANT && fast_raw > CSR_FAST_LOW_MAX_MA) ?
                         CSR_FAST_LOW_MAX_MA : fast_raw; // [RQ2]
  // Constant divide costs some area; kept exact rather than a shift approximation
  wire [12:0] fast_eff = ovrd ? 13'(fast_lim / CSR_FAST_REDUCE_DIV) : fast_lim; // [RQ5]
  wire [11:0] pre_raw = pt_decode(pre_code);
  wire [11:0] pre_eff = ovrd ? (pre_raw >> 1) : pre_raw; // [RQ5]
  wire [12:0] volt_raw = 13'(CSR_VOLT_OFS_MV + 13'(volt_code) * CSR_VOLT_LSB_MV); // [RQ8]
  // Codes above the top of range are held at the range limit
  wire [12:0] volt_eff = (volt_raw > CSR_VOLT_MAX_MV) ? CSR_VOLT_MAX_MV : volt_raw; // [RQ8]

  // Outputs come straight from the stored bytes, so they update the cycle after a write
  assign fast_current_code_o = fast_code; // [RQ13]
  assign reduced_current_override_o = ovrd;
  assign precondition_current_code_o = pre_code;
  assign end_of_charge_current_code_o = term_code;
  assign target_voltage_code_o = volt_code;
  assign precondition_exit_threshold_o = chg_volt[CSR_LOWV_BIT];
  assign restart_threshold_select_o = chg_volt[CSR_RECH_BIT];
  assign fast_current_ma_o = fast_eff;
  assign precharge_current_ma_o = pre_eff;
  assign term_current_ma_o = pt_decode(term_code); // [RQ6]
  assign charge_voltage_mv_o = volt_eff;
  assign precharge_exit_mv_o = chg_volt[CSR_LOWV_BIT] ? CSR_LOWV_1_MV : CSR_LOWV_0_MV; // [RQ10]
  assign recharge_drop_mv_o = chg_volt[CSR_RECH_BIT] ? CSR_RECH_1_MV : CSR_RECH_0_MV; // [RQ11]

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_fast_decode;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (!ovrd && !LOW_CURRENT_VARIANT) |->
        fast_current_ma_o == 13'(512 + 64 * int'(fast_current_code_o));
  endproperty
  a_fast_decode: assert property (p_fast_decode) else $error("fast current decode wrong"); // [RQ1]

  property p_low_clamp;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      LOW_CURRENT_VARIANT |-> fast_current_ma_o <= 13'd2496;
  endproperty
  a_low_clamp: assert property (p_low_clamp) else $error("low variant exceeds limit"); // [RQ2]

  property p_reset_values;
    @(posedge clk_sys_i)
      $rose(nrst_i) |-> fast_current_code_o == 6'h18 && precondition_current_code_o == 4'h1
        && end_of_charge_current_code_o == 4'h1 && target_voltage_code_o == 6'h2C;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("wrong reset values"); // [RQ3]

  property p_rsvd_zero;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr_en && sel_cur) |=> chg_cur[CSR_RSVD_BIT] == 1'b0 && chg_cur[7:2] == $past(reg_wdata_i[7:2]);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit stored"); // [RQ4]

  // Expected values worked from the raw codes, so a broken divider or clamp shows up here
  property p_reduce;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      reduced_current_override_o |->
        precharge_current_ma_o == 12'((128 + 128 * int'(precondition_current_code_o)) / 2)
        && fast_current_ma_o == 13'(((LOW_CURRENT_VARIANT && int'(fast_current_code_o) > 31)
           ? 2496 : 512 + 64 * int'(fast_current_code_o)) / 5);
  endproperty
  a_reduce: assert property (p_reduce) else $error("override scaling wrong"); // [RQ5]

  property p_term_decode;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      term_current_ma_o == 12'(128 + 128 * int'(end_of_charge_current_code_o));
  endproperty
  a_term_decode: assert property (p_term_decode) else $error("termination decode wrong"); // [RQ6]

  property p_volt_decode;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (target_voltage_code_o <= 6'h38) |->
        charge_voltage_mv_o == 13'(3504 + 16 * int'(target_voltage_code_o));
  endproperty
  a_volt_decode: assert property (p_volt_decode) else $error("voltage decode wrong"); // [RQ8]

  property p_thresholds;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      precharge_exit_mv_o == (precondition_exit_threshold_o ? 12'd3000 : 12'd2800)
        && recharge_drop_mv_o == (restart_threshold_select_o ? 9'd300 : 9'd100);
  endproperty
  a_thresholds: assert property (p_thresholds) else $error("threshold select wrong"); // [RQ10] [RQ11]

  property p_read_back;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (ce_i && reg_rd_i && sel_volt && !reg_wr_i) |=> reg_rdata_o == chg_volt;
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data mismatch"); // [RQ12]

  property p_write_effect;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr_en && sel_volt) |=> target_voltage_code_o == $past(reg_wdata_i[7:2])
        && restart_threshold_select_o == $past(reg_wdata_i[0]);
  endproperty
  a_write_effect: assert property (p_write_effect) else $error("write not applied"); // [RQ13]

  property p_foreign_addr;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (reg_wr_i && !dev_sel) |=> $stable(chg_cur) && $stable(pre_term) && $stable(chg_volt);
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("write to other device taken"); // [RQ12]

  property p_ce_freeze;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !ce_i |=> $stable(chg_cur) && $stable(pre_term) && $stable(chg_volt)
        && $stable(reg_rdata_o);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low"); // [RQ13]

  property p_rdata_hold;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !(ce_i && reg_rd_i) |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read"); // [RQ12]

  property p_unmapped_read;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (ce_i && reg_rd_i && !reg_hit_o) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // [RQ12]

endmodule : csr_setpoint_bank
`default_nettype wire

// [verif/csr_host_model.sv]
// Purpose: Host model driving the register port of the setpoint bank
// Assumes: One byte per strobe, strobes launched on the falling clock edge
// Notes: Released write data shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module csr_host_model
  import csr_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Register port
  output logic [6:0] dev_addr_o = CSR_DEV_ADDR,
  output logic [7:0] reg_addr_o = 8'h00,
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0,
  output logic [7:0] reg_wdata_o = 8'h00
);
  // -----------------------------------------------------------------
  // One access, then a spare cycle so results have landed
  // -----------------------------------------------------------------
  task automatic xfer(input logic [6:0] dev, input logic [7:0] ofs, input logic wr,
                      input logic [7:0] d);
    @(negedge clk_sys_i);
    dev_addr_o = dev;
    reg_addr_o = ofs;
    reg_wdata_o = (ofs == CSR_OFS_CHG_CUR) ? (d & 8'hFD) : d;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    @(negedge clk_sys_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = ~reg_wdata_o;
    @(negedge clk_sys_i);
  endtask : xfer
endmodule : csr_host_model
`default_nettype wire

// [verif/csr_setpoint_bank_tb_top.sv]
// Purpose: Self-checking bench for the charge setpoint bank
// Assumes: Full-current build as dut_u, lower-current build on the same port beside it
// Notes: All inputs change on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module csr_setpoint_bank_tb_top
  import csr_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic [6:0] dev;
  logic [7:0] ofs, wd, rdat;
  logic wr, rd, hit;
  logic [12:0] fc, fcl, cv, e, el;
  logic [5:0] fcd, vcd;
  logic [3:0] pcd, tcd;
  logic ov, lv, rs;
  logic [11:0] pc, tc, pe;
  logic [8:0] rv;
  logic [5:0] cs[3] = '{6'h00, 6'h18, 6'h3F};
  logic [5:0] vs[3] = '{6'h00, 6'h38, 6'h3F};
  int fail_count = 0;
  int checks_done = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  csr_host_model host_u (.clk_sys_i(clk_sys_i), .dev_addr_o(dev), .reg_addr_o(ofs),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wd));
  csr_setpoint_bank dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .dev_addr_i(dev), .reg_addr_i(ofs), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_hit_o(hit), .fast_current_code_o(fcd),
    .reduced_current_override_o(ov), .precondition_current_code_o(pcd),
    .end_of_charge_current_code_o(tcd), .target_voltage_code_o(vcd),
    .precondition_exit_threshold_o(lv), .restart_threshold_select_o(rs),
    .fast_current_ma_o(fc), .precharge_current_ma_o(pc), .term_current_ma_o(tc),
    .charge_voltage_mv_o(cv), .precharge_exit_mv_o(pe), .recharge_drop_mv_o(rv));
  // Lower-current build shares the port so the clamp sees the same writes
  csr_setpoint_bank #(.LOW_CURRENT_VARIANT(1'b1)) dut_low_u (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .ce_i(ce_i), .dev_addr_i(dev), .reg_addr_i(ofs), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(), .reg_hit_o(), .fast_current_code_o(),
    .reduced_current_override_o(), .precondition_current_code_o(),
    .end_of_charge_current_code_o(), .target_voltage_code_o(),
    .precondition_exit_threshold_o(), .restart_threshold_select_o(),
    .fast_current_ma_o(fcl), .precharge_current_ma_o(), .term_current_ma_o(),
    .charge_voltage_mv_o(), .precharge_exit_mv_o(), .recharge_drop_mv_o());
  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(CSR_DEV_ADDR, a, 1'b1, d);
  endtask : wrr
  task automatic rdr(input logic [7:0] a, input logic [7:0] exp);
    host_u.xfer(CSR_DEV_ADDR, a, 1'b0, 8'h00);
    chk(13'(rdat), 13'(exp), "readback");
  endtask : rdr
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    rdr(CSR_OFS_CHG_CUR, 8'h60);
    rdr(CSR_OFS_PRE_TERM, 8'h11);
    rdr(CSR_OFS_CHG_VOLT, 8'hB2);
    chk(fc, 13'h0800, "fast");
    chk(fcl, 13'h0800, "fast low");
    chk(13'({fcd, 1'b0, ov}), 13'h0060, "cur fields");
    chk(13'({pcd, tcd}), 13'h0011, "pt fields");
    chk(13'({vcd, lv, rs}), 13'h00B2, "volt fields");
    chk(13'(pc), 13'h0100, "pre");
    chk(13'(tc), 13'h0100, "term");
    chk(cv, 13'h1070, "volt");
    chk(13'(pe), 13'h0BB8, "exit");
    chk(13'(rv), 13'h0064, "drop");
    $display("test reset done");
  endtask : t_reset
  task automatic t_fast();
    for (int i = 0; i < 6; i++) begin
      wrr(CSR_OFS_CHG_CUR, {cs[i/2], 1'b1, i[0]});
      rdr(CSR_OFS_CHG_CUR, {cs[i/2], 1'b0, i[0]});
      chk(13'({fcd, ov}), 13'({cs[i/2], i[0]}), "cur fields");
      e = 13'(CSR_FAST_OFS_MA + CSR_FAST_LSB_MA * cs[i/2]);
      el = (e > CSR_FAST_LOW_MAX_MA) ? CSR_FAST_LOW_MAX_MA : e;
      if (i[0]) begin
        e = e / CSR_FAST_REDUCE_DIV;
        el = el / CSR_FAST_REDUCE_DIV;
      end
      chk(fc, e, "fast");
      chk(fcl, el, "fast low");
      chk(13'(pc), i[0] ? 13'h0080 : 13'h0100, "pre");
    end
    $display("test fast current done");
  endtask : t_fast
  task automatic t_pt();
    // The fast-current test leaves the override set; clear it first
    wrr(CSR_OFS_CHG_CUR, 8'h60);
    wrr(CSR_OFS_PRE_TERM, 8'hF0);
    chk(13'({pcd, tcd}), 13'h00F0, "pt fields");
    chk(13'(pc), 13'h0800, "pre");
    chk(13'(tc), 13'h0080, "term");
    wrr(CSR_OFS_CHG_CUR, 8'h01);
    chk(13'(pc), 13'h0400, "pre half");
    chk(13'(tc), 13'h0080, "term kept");
    wrr(CSR_OFS_PRE_TERM, 8'h0F);
    chk(13'(pc), 13'h0040, "pre half");
    chk(13'(tc), 13'h0800, "term");
    wrr(CSR_OFS_CHG_CUR, 8'h60);
    $display("test precharge done");
  endtask : t_pt
  task automatic t_volt();
    for (int i = 0; i < 12; i++) begin
      wrr(CSR_OFS_CHG_VOLT, {vs[i/4], i[1:0]});
      rdr(CSR_OFS_CHG_VOLT, {vs[i/4], i[1:0]});
      e = 13'(CSR_VOLT_OFS_MV + CSR_VOLT_LSB_MV * vs[i/4]);
      if (e > 13'h1130) e = 13'h1130;
      chk(cv, e, "volt");
      chk(13'({vcd, lv, rs}), 13'({vs[i/4], i[1:0]}), "volt fields");
      chk(13'(pe), i[1] ? 13'h0BB8 : 13'h0AF0, "exit");
      chk(13'(rv), i[0] ? 13'h012C : 13'h0064, "drop");
    end
    $display("test voltage done");
  endtask : t_volt
  task automatic t_refuse();
    wrr(CSR_OFS_CHG_VOLT, 8'hB2);
    host_u.xfer(7'h6A, CSR_OFS_CHG_VOLT, 1'b1, 8'h00);
    chk(13'(hit), 13'h0000, "hit foreign");
    rdr(CSR_OFS_CHG_VOLT, 8'hB2);
    chk(13'(hit), 13'h0001, "hit");
    host_u.xfer(7'h6A, CSR_OFS_CHG_VOLT, 1'b0, 8'h00);
    chk(13'(rdat), 13'h0000, "foreign read");
    host_u.xfer(CSR_DEV_ADDR, 8'h05, 1'b1, 8'hFF);
    rdr(8'h05, 8'h00);
    ce_i = 1'b0;
    wrr(CSR_OFS_CHG_VOLT, 8'h00);
    ce_i = 1'b1;
    rdr(CSR_OFS_CHG_VOLT, 8'hB2);
    chk(cv, 13'h1070, "volt");
    $display("test refusal done");
  endtask : t_refuse
  task automatic t_rerst();
    wrr(CSR_OFS_CHG_CUR, 8'h01);
    wrr(CSR_OFS_PRE_TERM, 8'hF0);
    wrr(CSR_OFS_CHG_VOLT, 8'h01);
    rdr(CSR_OFS_CHG_VOLT, 8'h01);
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk(13'(rdat), 13'h0000, "rdata in reset");
    nrst_i = 1'b1;
    t_reset();
    $display("test mid-run reset done");
  endtask : t_rerst
  initial begin
    repeat (20) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    t_reset();
    t_fast();
    t_pt();
    t_volt();
    t_refuse();
    t_rerst();
    report_and_stop();
  end
  // Whole run needs about 200 cycles
  initial begin
    #20000;
    fail_count++;
    report_and_stop();
  end
endmodule : csr_setpoint_bank_tb_top
`default_nettype wire
